// >>> cpu_status_pkg.sv
// Constants shared by the CPU status and core control bank.
// Assumes a single 250 MHz CPU clock and a synchronous reset.
package cpu_status_pkg;

   localparam int unsigned DATA_W = 16;
   localparam int unsigned ADDR_W = 4;

   // Register word addresses on the plain register port
   localparam logic [3:0] OFS_FLAGS = 4'h0;
   localparam logic [3:0] OFS_CORE  = 4'h2;

   // cpu_flags_word field positions
   localparam int unsigned BIT_HALF_CARRY = 8;
   localparam int unsigned IPL_LOW_MSB    = 7;
   localparam int unsigned IPL_LOW_LSB    = 5;
   localparam int unsigned BIT_REPEAT     = 4;
   localparam int unsigned BIT_NEG        = 3;
   localparam int unsigned BIT_WRAP       = 2;
   localparam int unsigned BIT_ZERO       = 1;
   localparam int unsigned BIT_CARRY      = 0;

   // core_control_word field positions
   localparam int unsigned BIT_EARLY_EXIT = 11;
   localparam int unsigned DEPTH_MSB      = 10;
   localparam int unsigned DEPTH_LSB      = 8;
   localparam int unsigned BIT_IPL_HIGH   = 3;

   // Plain read/write bits of core_control_word (12, 7..4, 2..0)
   localparam logic [15:0] CORE_RW_MASK = 16'h10F7;

   // Values after reset
   localparam logic [15:0] RST_CORE    = 16'h0020;
   localparam logic [2:0]  RST_IPL_LOW = 3'h0;
   localparam logic [2:0]  RST_DEPTH   = 3'h0;

   // Encodings
   localparam logic [2:0] IPL_LOW_BLOCK   = 3'h7;
   localparam logic [2:0] LOOP_DEPTH_MAX  = 3'h7;
   localparam logic [2:0] LOOP_DEPTH_NONE = 3'h0;

   typedef enum logic [0:0] {
      EXIT_IDLE,
      EXIT_WAIT
   } exit_state_t;

endpackage

// >>> alu_op_if.sv
// Carries one ALU operation to the flag calculator and its answer back.
// Assumes both ends sit in the CPU clock domain; purely combinational.
`timescale 1ns/100ps
`default_nettype none
interface alu_op_if;
   logic        byte_op;
   logic        sub;
   logic        with_carry;
   logic        carry_in;
   logic [15:0] a;
   logic [15:0] b;
   logic [15:0] result;
   logic        half_carry;
   logic        carry;
   logic        neg;
   logic        wrap;
   logic        nonzero;

   modport calc (input byte_op, sub, with_carry, carry_in, a, b,
                 output result, half_carry, carry, neg, wrap, nonzero);
   modport bank (output byte_op, sub, with_carry, carry_in, a, b,
                 input result, half_carry, carry, neg, wrap, nonzero);
endinterface
`default_nettype wire

// >>> alu_flag_calc.sv
// Add/subtract datapath that derives the ALU status flags.
// Assumes operands stand for the cycle in which the bank samples them.
`timescale 1ns/100ps
`default_nettype none
module alu_flag_calc (
   alu_op_if.calc op
);
   logic [15:0] b_eff;
   logic        cin;
   logic [4:0]  sum4;
   logic [8:0]  sum8;
   logic [16:0] sum16;
   logic        a_msb;
   logic        b_msb;
   logic        r_msb;

   // Subtract is a plus not-b plus one, so carry means no borrow
   always_comb begin
      b_eff = op.sub ? ~op.b : op.b;
      cin   = op.with_carry ? op.carry_in : op.sub;
      sum4  = {1'b0, op.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
      sum8  = {1'b0, op.a[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, cin};
      sum16 = {1'b0, op.a} + {1'b0, b_eff} + {16'h0000, cin};
      a_msb = op.byte_op ? op.a[7] : op.a[15];
      b_msb = op.byte_op ? b_eff[7] : b_eff[15];
      r_msb = op.byte_op ? sum8[7] : sum16[15];
      op.result     = op.byte_op ? {8'h00, sum8[7:0]} : sum16[15:0];
      op.half_carry = op.byte_op ? sum4[4] : sum8[8];
      op.carry      = op.byte_op ? sum8[8] : sum16[16];
      op.neg        = r_msb;
      op.wrap       = (a_msb == b_msb) && (r_msb != a_msb);
      op.nonzero    = op.byte_op ? |sum8[7:0] : |sum16[15:0];
   end
endmodule
`default_nettype wire

// >>> loop_tracker.sv
// Repeat-loop activity flag, do-loop nesting depth and early exit.
// Assumes loop events come from the sequencer on the same clock.
`timescale 1ns/100ps
`default_nettype none
module loop_tracker (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_repeat_start,
   input  wire logic       i_repeat_done,
   input  wire logic       i_do_start,
   input  wire logic       i_do_end,
   input  wire logic       i_do_iter_end,
   input  wire logic       i_exit_req,
   output logic            o_repeat_active,
   output logic [2:0]      o_depth,
   output logic            o_exit_pending,
   output logic            o_loop_exit
);
   typedef struct packed {
      logic                       repeat_active;
      logic [2:0]                 depth;
      cpu_status_pkg::exit_state_t exit_st;
      logic                       loop_exit;
   } loop_state_t;

   loop_state_t s_q;
   loop_state_t s_d;
   logic        leave;

   // Exit waits for the end of the running iteration before firing
   always_comb begin
      s_d       = s_q;
      leave     = 1'b0;
      s_d.loop_exit = 1'b0;
      if (i_repeat_start) begin
         s_d.repeat_active = 1'b1;
      end else if (i_repeat_done) begin
         s_d.repeat_active = 1'b0;
      end
      case (s_q.exit_st)
         cpu_status_pkg::EXIT_IDLE: begin
            if (i_exit_req &&
                s_q.depth != cpu_status_pkg::LOOP_DEPTH_NONE) begin
               s_d.exit_st = cpu_status_pkg::EXIT_WAIT;
            end
         end
         cpu_status_pkg::EXIT_WAIT: begin
            if (i_do_iter_end) begin
               leave         = 1'b1;
               s_d.loop_exit = 1'b1;
               s_d.exit_st   = cpu_status_pkg::EXIT_IDLE;
            end
         end
         default: s_d.exit_st = cpu_status_pkg::EXIT_IDLE;
      endcase
      // Depth saturates so a runaway push cannot wrap to zero
      if ((i_do_end || leave) && !i_do_start) begin
         if (s_q.depth != cpu_status_pkg::LOOP_DEPTH_NONE) begin
            s_d.depth = s_q.depth - 3'h1;
         end
      end else if (i_do_start && !(i_do_end || leave)) begin
         if (s_q.depth != cpu_status_pkg::LOOP_DEPTH_MAX) begin
            s_d.depth = s_q.depth + 3'h1;
         end
      end
   end

   // State register
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s_q <= '{repeat_active: 1'b0,
                  depth:         cpu_status_pkg::RST_DEPTH,
                  exit_st:       cpu_status_pkg::EXIT_IDLE,
                  loop_exit:     1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign o_repeat_active = s_q.repeat_active;
   assign o_depth         = s_q.depth;
   assign o_exit_pending  = (s_q.exit_st == cpu_status_pkg::EXIT_WAIT);
   assign o_loop_exit     = s_q.loop_exit;
endmodule
`default_nettype wire

// >>> cpu_status_core_control.sv
// CPU status word (low half) and core control word register bank.
// Assumes a CPU sequencer, ALU operand source and interrupt controller
// on the same clock; software reaches the words over a plain port.
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`default_nettype none
module cpu_status_core_control (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // Register port
   input  wire logic [3:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [15:0]      o_rdata,
   // ALU operation
   input  wire logic        i_alu_valid,
   input  wire logic        i_alu_byte,
   input  wire logic        i_alu_sub,
   input  wire logic        i_alu_with_carry,
   input  wire logic        i_alu_keep_zero,
   input  wire logic [15:0] i_alu_a,
   input  wire logic [15:0] i_alu_b,
   output logic [15:0]      o_alu_result,
   output logic [4:0]       o_alu_flags,
   // Loop sequencer
   input  wire logic        i_repeat_start,
   input  wire logic        i_repeat_done,
   input  wire logic        i_do_start,
   input  wire logic        i_do_end,
   input  wire logic        i_do_iter_end,
   output logic             o_repeat_active,
   output logic [2:0]       o_loop_depth,
   output logic             o_loop_exit,
   // Interrupt controller
   input  wire logic        i_nest_disable,
   input  wire logic        i_ipl_load,
   input  wire logic [3:0]  i_ipl_value,
   output logic [3:0]       o_cpu_priority,
   output logic             o_user_irq_blocked,
   output logic [15:0]      o_core_control
);

   typedef struct packed {
      logic        half_carry;
      logic [2:0]  ipl_low;
      logic        neg;
      logic        wrap;
      logic        zero;
      logic        carry;
      logic [15:0] core;
      logic        blocked;
      logic [15:0] result;
      logic [15:0] rdata;
   } bank_state_t;

   bank_state_t s_q;
   bank_state_t s_d;

   alu_op_if    alu ();

   logic        loop_repeat;
   logic [2:0]  loop_depth;
   logic        loop_pending;
   logic        loop_exit;
   logic        exit_req;
   logic        wr_flags;
   logic        wr_core;
   logic        rd_flags;
   logic        rd_core;
   logic [15:0] flags_word;
   logic [15:0] core_word;

   // Level 7 on the low bits, or any level with the high bit, masks
   // user interrupts; used for both the hardware and software paths.
   function automatic logic user_block(input logic       high,
                                       input logic [2:0] low);
      user_block = high || (low == cpu_status_pkg::IPL_LOW_BLOCK);
   endfunction

   // Replace only the bits selected by the mask
   function automatic logic [15:0] merge(input logic [15:0] old_v,
                                         input logic [15:0] new_v,
                                         input logic [15:0] mask);
      merge = (old_v & ~mask) | (new_v & mask);
   endfunction

   // Register strobe decode
   assign wr_flags = i_wr && (i_addr == cpu_status_pkg::OFS_FLAGS);
   assign wr_core  = i_wr && (i_addr == cpu_status_pkg::OFS_CORE);
   assign rd_flags = i_rd && (i_addr == cpu_status_pkg::OFS_FLAGS);
   assign rd_core  = i_rd && (i_addr == cpu_status_pkg::OFS_CORE);

   // Writing one to the early exit bit only requests; it never stores
   assign exit_req = wr_core && i_wdata[cpu_status_pkg::BIT_EARLY_EXIT];

   // ALU request; the stored carry feeds add/subtract with carry
   assign alu.byte_op    = i_alu_byte;
   assign alu.sub        = i_alu_sub;
   assign alu.with_carry = i_alu_with_carry;
   assign alu.carry_in   = s_q.carry;
   assign alu.a          = i_alu_a;
   assign alu.b          = i_alu_b;

   alu_flag_calc u_calc (
      .op (alu.calc)
   );

   loop_tracker u_loop (
      .i_clk           (i_clk),
      .i_rst           (i_rst),
      .i_repeat_start  (i_repeat_start),
      .i_repeat_done   (i_repeat_done),
      .i_do_start      (i_do_start),
      .i_do_end        (i_do_end),
      .i_do_iter_end   (i_do_iter_end),
      .i_exit_req      (exit_req),
      .o_repeat_active (loop_repeat),
      .o_depth         (loop_depth),
      .o_exit_pending  (loop_pending),
      .o_loop_exit     (loop_exit)
   );

   // Read views of both words from the current register contents
   always_comb begin
      flags_word = 16'h0000;
      flags_word[cpu_status_pkg::BIT_HALF_CARRY] = s_q.half_carry;
      flags_word[cpu_status_pkg::IPL_LOW_MSB:cpu_status_pkg::IPL_LOW_LSB]
         = s_q.ipl_low;
      flags_word[cpu_status_pkg::BIT_REPEAT] = loop_repeat;
      flags_word[cpu_status_pkg::BIT_NEG]    = s_q.neg;
      flags_word[cpu_status_pkg::BIT_WRAP]   = s_q.wrap;
      flags_word[cpu_status_pkg::BIT_ZERO]   = s_q.zero;
      flags_word[cpu_status_pkg::BIT_CARRY]  = s_q.carry;
   end

   // Upper three bits are never stored, so they always read zero
   always_comb begin
      core_word = s_q.core;
      core_word[cpu_status_pkg::DEPTH_MSB:cpu_status_pkg::DEPTH_LSB]
         = loop_depth;
      core_word[cpu_status_pkg::BIT_EARLY_EXIT] = loop_pending;
   end

   // Next-state logic for the whole bank
   always_comb begin
      s_d = s_q;

      // Software writes to the plain flag bits come first so that an
      // ALU update in the same cycle overrides them.
      if (wr_flags) begin
         s_d.half_carry = i_wdata[cpu_status_pkg::BIT_HALF_CARRY];
         s_d.neg        = i_wdata[cpu_status_pkg::BIT_NEG];
         s_d.wrap       = i_wdata[cpu_status_pkg::BIT_WRAP];
         s_d.zero       = i_wdata[cpu_status_pkg::BIT_ZERO];
         s_d.carry      = i_wdata[cpu_status_pkg::BIT_CARRY];
         if (!i_nest_disable) begin
            s_d.ipl_low = i_wdata[cpu_status_pkg::IPL_LOW_MSB:
                                  cpu_status_pkg::IPL_LOW_LSB];
         end
      end

      // ALU result updates every arithmetic flag except zero on a zero word with i_alu_keep_zero
      if (i_alu_valid) begin
         s_d.half_carry = alu.half_carry;
         s_d.neg        = alu.neg;
         s_d.wrap       = alu.wrap;
         s_d.carry      = alu.carry;
         s_d.result     = alu.result;
         // Multi-word ops only ever clear zero, so one nonzero word
         // anywhere in the chain leaves it clear.
         if (alu.nonzero) begin
            s_d.zero = 1'b0;
         end else if (!i_alu_keep_zero) begin
            s_d.zero = 1'b1;
         end
      end

      // Plain read/write core control bits
      if (wr_core) begin
         s_d.core = merge(s_q.core, i_wdata,
                          cpu_status_pkg::CORE_RW_MASK);
         // Priority high bit is clear-only for software
         if (!i_wdata[cpu_status_pkg::BIT_IPL_HIGH]) begin
            s_d.core[cpu_status_pkg::BIT_IPL_HIGH] = 1'b0;
         end
      end

      // Interrupt controller loads the full level; it is the only
      // party that can raise the high bit, and it wins over a clear.
      if (i_ipl_load) begin
         s_d.core[cpu_status_pkg::BIT_IPL_HIGH] = i_ipl_value[3];
         s_d.ipl_low = i_ipl_value[2:0];
      end

      s_d.blocked = user_block(s_d.core[cpu_status_pkg::BIT_IPL_HIGH],
                               s_d.ipl_low);

      // Read data stand only in the cycle after the strobe
      if (rd_flags) begin
         s_d.rdata = flags_word;
      end else if (rd_core) begin
         s_d.rdata = core_word;
      end else begin
         s_d.rdata = 16'h0000;
      end
   end

   // Bank registers
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s_q <= '{half_carry: 1'b0,
                  ipl_low:    cpu_status_pkg::RST_IPL_LOW,
                  neg:        1'b0,
                  wrap:       1'b0,
                  zero:       1'b0,
                  carry:      1'b0,
                  core:       cpu_status_pkg::RST_CORE,
                  blocked:    1'b0,
                  result:     16'h0000,
                  rdata:      16'h0000};
      end else begin
         s_q <= s_d;
      end
   end

   // Four-bit priority: high bit above the low three; a one on top
   // therefore means a level above seven.
   assign o_cpu_priority = {s_q.core[cpu_status_pkg::BIT_IPL_HIGH],
                            s_q.ipl_low};
   assign o_user_irq_blocked = s_q.blocked;

   // Outputs straight from registers
   assign o_rdata         = s_q.rdata;
   assign o_alu_result    = s_q.result;
   assign o_alu_flags     = {s_q.half_carry, s_q.neg, s_q.wrap,
                             s_q.zero, s_q.carry};
   assign o_core_control  = s_q.core;
   assign o_repeat_active = loop_repeat;
   assign o_loop_depth    = loop_depth;
   assign o_loop_exit     = loop_exit;

endmodule
`default_nettype wire

// >>> cpu_status_core_control_sva.sv
// Concurrent checks on the ports of the CPU status and core control bank.
// Assumes one clock domain and a synchronous, active-high reset.
`timescale 1ns/100ps
`default_nettype none
module cpu_status_core_control_sva (
   input wire logic        i_clk,
   input wire logic        i_rst,
   input wire logic        i_alu_valid,
   input wire logic        i_alu_byte,
   input wire logic        i_alu_keep_zero,
   input wire logic [15:0] o_alu_result,
   input wire logic [4:0]  o_alu_flags,
   input wire logic        i_repeat_start,
   input wire logic        o_repeat_active,
   input wire logic        i_do_start,
   input wire logic        i_do_end,
   input wire logic        i_do_iter_end,
   input wire logic [2:0]  o_loop_depth,
   input wire logic        o_loop_exit,
   input wire logic        i_nest_disable,
   input wire logic        i_ipl_load,
   input wire logic [3:0]  i_ipl_value,
   input wire logic [3:0]  o_cpu_priority,
   input wire logic        o_user_irq_blocked,
   input wire logic [15:0] o_core_control
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   // Early exit is a single pulse that follows an iteration end
   sequence s_one_shot; o_loop_exit ##1 !o_loop_exit; endsequence
   sequence s_iter_seen; $past(i_do_iter_end); endsequence

   property p_blocked;
      o_user_irq_blocked == (o_cpu_priority[3] || o_cpu_priority[2:0] == 3'h7);
   endproperty
   a_blocked: assert property (p_blocked) else $error("blocked mismatch");
   property p_ipl_load; i_ipl_load |=> o_cpu_priority == $past(i_ipl_value); endproperty
   a_ipl_load: assert property (p_ipl_load) else $error("priority load");
   property p_nest_hold;
      i_nest_disable && !i_ipl_load |=> $stable(o_cpu_priority[2:0]);
   endproperty
   a_nest_hold: assert property (p_nest_hold) else $error("low bits moved");
   // Software may only clear the high priority bit, never set it
   property p_high_clear; !o_cpu_priority[3] && !i_ipl_load |=> !o_cpu_priority[3]; endproperty
   a_high_clear: assert property (p_high_clear) else $error("high bit set by sw");
   property p_core_top; o_core_control[15:13] == 3'h0; endproperty
   a_core_top: assert property (p_core_top) else $error("core top bits set");
   property p_repeat; i_repeat_start |=> o_repeat_active; endproperty
   a_repeat: assert property (p_repeat) else $error("repeat flag late");
   property p_depth_hold;
      !(i_do_start || i_do_end || i_do_iter_end) |=> $stable(o_loop_depth);
   endproperty
   a_depth_hold: assert property (p_depth_hold) else $error("depth moved");
   property p_exit; o_loop_exit |-> s_iter_seen ##0 s_one_shot; endproperty
   a_exit: assert property (p_exit) else $error("exit pulse wrong");
   // Multi-word zero test may only clear the flag
   property p_zero;
      i_alu_valid && i_alu_keep_zero |=>
         o_alu_flags[1] == ($past(o_alu_flags[1]) && o_alu_result == 16'h0000);
   endproperty
   a_zero: assert property (p_zero) else $error("sticky zero wrong");
   property p_neg; i_alu_valid && !i_alu_byte |=> o_alu_flags[3] == o_alu_result[15]; endproperty
   a_neg: assert property (p_neg) else $error("negative flag wrong");
endmodule

bind cpu_status_core_control cpu_status_core_control_sva sva_inst (
   .i_clk(i_clk), .i_rst(i_rst), .i_alu_valid(i_alu_valid),
   .i_alu_byte(i_alu_byte), .i_alu_keep_zero(i_alu_keep_zero),
   .o_alu_result(o_alu_result), .o_alu_flags(o_alu_flags),
   .i_repeat_start(i_repeat_start), .o_repeat_active(o_repeat_active),
   .i_do_start(i_do_start), .i_do_end(i_do_end),
   .i_do_iter_end(i_do_iter_end), .o_loop_depth(o_loop_depth),
   .o_loop_exit(o_loop_exit), .i_nest_disable(i_nest_disable),
   .i_ipl_load(i_ipl_load), .i_ipl_value(i_ipl_value),
   .o_cpu_priority(o_cpu_priority),
   .o_user_irq_blocked(o_user_irq_blocked), .o_core_control(o_core_control)
);
`default_nettype wire

// >>> cpu_status_core_control_test.sv
// Self-checking bench for the CPU status and core control bank.
// Assumes the design and the bound checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module cpu_status_core_control_test;
   logic        clk;
   logic        rst;
   logic [3:0]  addr;
   logic [15:0] wdata;
   logic        wr;
   logic        rd;
   logic [15:0] rdata;
   logic [4:0]  alu_ctl;   // {valid, byte, sub, with_carry, keep_zero}
   logic [15:0] alu_a;
   logic [15:0] alu_b;
   logic [15:0] alu_res;
   logic [4:0]  alu_flags;
   logic [4:0]  loop_ev;   // {rep_start, rep_done, do_start, do_end, iter}
   logic        rep_act;
   logic [2:0]  depth;
   logic        lp_exit;
   logic        nest_dis;
   logic        ipl_ld;
   logic [3:0]  ipl_val;
   logic [3:0]  prio;
   logic        blocked;
   logic [15:0] core;
   logic [4:0]  flags_exp;
   int          mismatches;
   int          n_compared;

   cpu_status_core_control cpu_status_core_control_inst (
      .i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
      .i_rd(rd), .o_rdata(rdata), .i_alu_valid(alu_ctl[4]),
      .i_alu_byte(alu_ctl[3]), .i_alu_sub(alu_ctl[2]),
      .i_alu_with_carry(alu_ctl[1]), .i_alu_keep_zero(alu_ctl[0]),
      .i_alu_a(alu_a), .i_alu_b(alu_b), .o_alu_result(alu_res),
      .o_alu_flags(alu_flags), .i_repeat_start(loop_ev[4]),
      .i_repeat_done(loop_ev[3]), .i_do_start(loop_ev[2]),
      .i_do_end(loop_ev[1]), .i_do_iter_end(loop_ev[0]),
      .o_repeat_active(rep_act), .o_loop_depth(depth), .o_loop_exit(lp_exit),
      .i_nest_disable(nest_dis), .i_ipl_load(ipl_ld), .i_ipl_value(ipl_val),
      .o_cpu_priority(prio), .o_user_irq_blocked(blocked),
      .o_core_control(core)
   );

   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      if (mismatches == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Reference flags {result, half, neg, wrap, zero, carry}
   function automatic logic [20:0] alu_ref(input logic [15:0] a, b,
                                           input logic byt, sub, cin);
      logic [15:0] bb;
      logic [16:0] s;
      logic [8:0]  h;
      logic [15:0] r;
      bb = sub ? ~b : b;
      if (byt) begin
         s = {9'h000, a[7:0]} + {9'h000, bb[7:0]} + {16'h0000, cin};
         h = {5'h00, a[3:0]} + {5'h00, bb[3:0]} + {8'h00, cin};
         r = {8'h00, s[7:0]};
         return {r, h[4], r[7], (a[7] == bb[7]) && (r[7] != a[7]),
                 r == 16'h0000, s[8]};
      end
      s = {1'b0, a} + {1'b0, bb} + {16'h0000, cin};
      h = {1'b0, a[7:0]} + {1'b0, bb[7:0]} + {8'h00, cin};
      r = s[15:0];
      return {r, h[8], r[15], (a[15] == bb[15]) && (r[15] != a[15]),
              r == 16'h0000, s[16]};
   endfunction

   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the read edge
   task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask

   task automatic loop_pulse(input logic [4:0] ev);
      @(posedge clk);
      loop_ev <= ev;
      @(posedge clk);
      loop_ev <= 5'h00;
      #1;
   endtask

   task automatic ipl_pulse(input logic [3:0] v);
      @(posedge clk);
      ipl_ld  <= 1'b1;
      ipl_val <= v;
      @(posedge clk);
      ipl_ld  <= 1'b0;
      #1;
   endtask

   // ctl = {byte, sub, with_carry, keep_zero}; carry in tracked by the bench
   task automatic alu_op(input logic [3:0] ctl, input logic [15:0] a, b);
      logic [20:0] e;
      e = alu_ref(a, b, ctl[3], ctl[2], ctl[1] ? flags_exp[0] : ctl[2]);
      if (ctl[0]) e[1] = e[1] & flags_exp[1];
      flags_exp = e[4:0];
      @(posedge clk);
      alu_ctl <= {1'b1, ctl};
      alu_a   <= a;
      alu_b   <= b;
      @(posedge clk);
      alu_ctl <= 5'h00;
      #1;
      chk(alu_res, e[20:5]);
      chk({11'h000, alu_flags}, {11'h000, e[4:0]});
   endtask

   task automatic t_reset();
      rd_reg(4'h0, 16'h0000);
      rd_reg(4'h2, 16'h0020);
      chk(core, 16'h0020);
      chk({6'h00, prio, blocked, rep_act, depth, lp_exit}, 16'h0000);
      chk(alu_res, 16'h0000);
      chk({11'h000, alu_flags}, 16'h0000);
   endtask

   // Writable bits, unmapped place and nesting lock
   task automatic t_regs();
      wr_reg(4'h2, 16'hFFFF);
      rd_reg(4'h2, 16'h10F7);
      wr_reg(4'h6, 16'hFFFF);
      rd_reg(4'h6, 16'h0000);
      chk(core, 16'h10F7);
      wr_reg(4'h2, 16'h0020);
      wr_reg(4'h0, 16'hFFFF);
      rd_reg(4'h0, 16'h01EF);
      chk({11'h000, blocked, prio}, 16'h0017);
      @(posedge clk);
      nest_dis <= 1'b1;
      wr_reg(4'h0, 16'h0000);
      rd_reg(4'h0, 16'h00E0);
      @(posedge clk);
      nest_dis <= 1'b0;
      wr_reg(4'h0, 16'h0000);
      rd_reg(4'h0, 16'h0000);
      flags_exp = 5'h00;
   endtask

   task automatic t_prio();
      for (int v = 0; v < 16; v++) begin
         ipl_pulse(v[3:0]);
         chk({12'h000, prio}, {12'h000, v[3:0]});
         chk({15'h0000, blocked}, {15'h0000, v[3] | (v[2:0] == 3'h7)});
         rd_reg(4'h0, {8'h00, v[2:0], 5'h00});
         rd_reg(4'h2, {12'h002, v[3], 3'h0});
      end
      wr_reg(4'h2, 16'h0020);
      wr_reg(4'h2, 16'h0028);
      chk({12'h000, prio}, 16'h0007);
      ipl_pulse(4'h0);
   endtask

   task automatic t_alu();
      alu_op(4'h0, 16'h7FFF, 16'h0001);
      alu_op(4'h0, 16'hFFFF, 16'h0001);
      alu_op(4'h1, 16'h0000, 16'h0000);
      alu_op(4'h1, 16'h0001, 16'h0000);
      alu_op(4'h1, 16'h0000, 16'h0000);
      alu_op(4'h4, 16'h0000, 16'h0001);
      alu_op(4'h4, 16'h8000, 16'h0001);
      alu_op(4'h2, 16'h0010, 16'h0020);
      alu_op(4'h8, 16'h000F, 16'h0001);
      alu_op(4'h8, 16'h007F, 16'h0001);
      alu_op(4'h8, 16'h12FF, 16'h3401);
      alu_op(4'hC, 16'h0000, 16'h0001);
      alu_op(4'h6, 16'h0005, 16'h0003);
      rd_reg(4'h0, {7'h00, flags_exp[4], 4'h0, flags_exp[3:0]});
   endtask

   // Repeat flag, saturating depth and early loop exit
   task automatic t_loops();
      loop_pulse(5'h10);
      // ALU flags left by the previous scenario still show beside it
      rd_reg(4'h0, {7'h00, flags_exp[4], 4'h1, flags_exp[3:0]});
      loop_pulse(5'h08);
      chk({15'h0000, rep_act}, 16'h0000);
      for (int i = 0; i < 8; i++) loop_pulse(5'h04);
      rd_reg(4'h2, 16'h0720);
      wr_reg(4'h2, 16'h0820);
      rd_reg(4'h2, 16'h0F20);
      loop_pulse(5'h01);
      chk({12'h000, lp_exit, depth}, 16'h000E);
      loop_pulse(5'h01);
      chk({12'h000, lp_exit, depth}, 16'h0006);
      for (int i = 0; i < 7; i++) loop_pulse(5'h02);
      chk({13'h0000, depth}, 16'h0000);
   endtask

   // Bound on the whole run
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      tally_and_finish();
   end

   initial begin
      rst = 1'b1;
      addr = 4'h0;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
      alu_ctl = 5'h00;
      alu_a = 16'h0000;
      alu_b = 16'h0000;
      loop_ev = 5'h00;
      nest_dis = 1'b0;
      ipl_ld = 1'b0;
      ipl_val = 4'h0;
      flags_exp = 5'h00;
      mismatches = 0;
      n_compared = 0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_regs();
      t_prio();
      t_alu();
      t_loops();
      tally_and_finish();
   end
endmodule
`default_nettype wire
